// [design/rmn_pkg.sv]
// shared constants, types and frame helpers of the reflective memory node
`default_nettype none

package rmn_pkg;

  // ==========================================================
  // bus and memory geometry
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int BYTE_W = 8;
  localparam int STRB_W = DATA_W / BYTE_W;
  localparam int MEM_AW = 16;              // 64K words, 256 Kbyte
  localparam int WORD_LSB = 2;             // byte address to word index
  localparam int FIFO_DEPTH_DEF = 128;     // 512 bytes of 32-bit words

  // ==========================================================
  // host window decode
  localparam int EXT_LSB = 24;             // A31..A24 field
  localparam int EXT_W = 8;
  localparam int STD_LSB = 18;             // A23..A18 field
  localparam int STD_W = 6;
  localparam int POS_W = 2;                // A19..A18: place in 1 Mbyte
  localparam logic [EXT_W-1:0] EXT_A24 = 8'h00;
  localparam int PROT_PRIV_BIT = 0;
  typedef enum logic [1:0] {
    AM_SUPER = 2'h0,
    AM_USER = 2'h1,
    AM_BOTH = 2'h2
  } rmn_am_t;

  // ==========================================================
  // register page and offsets
  localparam int REG_PAGE_LSB = 16;
  localparam logic [ADDR_W-REG_PAGE_LSB-1:0] REG_PAGE = 16'hFFFF;
  localparam int REG_OFF_W = 8;
  localparam logic [REG_OFF_W-1:0] REG_CSR = 8'h00;
  localparam logic [REG_OFF_W-1:0] REG_IRQ_CTRL = 8'h04;
  localparam logic [REG_OFF_W-1:0] REG_IRQ_STAT = 8'h08;
  localparam logic [REG_OFF_W-1:0] REG_IRQ_SEND = 8'h0C;

  // ==========================================================
  // register fields and reset values
  localparam int CSR_FAULT = 0;
  localparam int CSR_HALF = 1;
  localparam int CSR_FULL = 2;
  localparam int CSR_LERR = 3;
  localparam int CSR_NODE_LSB = 8;
  localparam int N_SRC = 3;                // half full, attention, link error
  localparam int SRC_HALF = 0;
  localparam int SRC_ATTN = 1;
  localparam int SRC_LERR = 2;
  localparam int IC_MASK_LSB = 0;
  localparam int IC_EN = 4;
  localparam int IC_LVL_LSB = 8;
  localparam int LVL_W = 3;
  localparam logic [LVL_W-1:0] IRQ_NONE = 3'h0;
  localparam int SEND_BCAST_BIT = 8;
  localparam logic FAULT_RST = 1'b1;

  // ==========================================================
  // link frame layout
  localparam int NODE_W = 8;
  localparam int OFF_W = 18;               // word offset inside 1 Mbyte
  localparam int FR_DATA_LSB = 0;
  localparam int FR_STRB_LSB = 32;
  localparam int FR_OFF_LSB = 36;
  localparam int FR_SRC_LSB = 54;
  localparam int FR_TYPE_BIT = 62;
  localparam int FR_PAR_BIT = 63;
  localparam int FRAME_W = 64;
  typedef enum logic {
    FR_WRITE = 1'b0,
    FR_IRQ = 1'b1
  } rmn_frame_t;

  // host port sequencer, gray along idle, read, done
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_MEMRD = 2'h1,
    ST_DONE = 2'h3
  } rmn_state_t;

  // even parity over every frame bit below the parity bit
  function automatic logic frame_parity(input logic [FRAME_W-1:0] f);
    return ^f[FR_PAR_BIT-1:0];
  endfunction : frame_parity

endpackage : rmn_pkg

`default_nettype wire

// [design/rmn_sram.sv]
// byte-lane shared memory with registered read data
`timescale 1ns/10ps
`default_nettype none

module rmn_sram
  import rmn_pkg::*;
#(
  parameter int AW = MEM_AW,
  parameter int DW = DATA_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // single access port
  input wire logic en,
  input wire logic we,
  input wire logic [DW/BYTE_W-1:0] strb,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);

  logic [DW-1:0] mem_ff [2**AW];
  logic [DW-1:0] rdata_ff;

  // byte-lane write
  always_ff @(posedge clk) begin
    if (en && we) begin
      for (int i = 0; i < DW / BYTE_W; i++) begin
        if (strb[i]) begin
          mem_ff[addr][i*BYTE_W +: BYTE_W] <= wdata[i*BYTE_W +: BYTE_W];
        end
      end
    end
  end

  // read word held until the next read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= '0;
    end else if (en && !we) begin
      rdata_ff <= mem_ff[addr];
    end
  end

  assign rdata = rdata_ff;

endmodule : rmn_sram

`default_nettype wire

// [design/rmn_fifo.sv]
// outgoing frame fifo with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none

module rmn_fifo #(
  parameter int W = 64,
  parameter int DEPTH = 128
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  // fill level
  output logic [$clog2(DEPTH):0] count
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_ff [DEPTH];
  logic [AW:0] wr_ptr_ff;
  logic [AW:0] rd_ptr_ff;
  logic push;
  logic pop;

  // handshakes and level, depth is a power of two
  assign count = wr_ptr_ff - rd_ptr_ff;
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem_ff[rd_ptr_ff[AW-1:0]];

  // storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff[AW-1:0]] <= in_data;
    end
  end

  // pointers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
    end
  end

endmodule : rmn_fifo

`default_nettype wire

// [design/rmn_node.sv]
// reflective memory node: apb host port, shared memory, link send and receive
`timescale 1ns/10ps
`default_nettype none

// Function
// (R1) every host memory write is queued to the link for all peers
// (R2) node numbers are eight bits, so up to 256 nodes share a link
// (R3) window answers supervisory, nonprivileged or both access kinds by strap
// (R4) window sits in the 24-bit or the 32-bit address space by strap
// (R5) byte strobes give 8, 16, 24 and 32 bit writes
// (R6) attention interrupt goes out on a programmable level one to seven
// (R7) a node can interrupt one chosen peer or all peers over the link
// (R8) 256 Kbyte local memory and a 512 byte outgoing buffer
// (R9) link writes own the memory first; host just sees a later ready
// (R10) link runs from reset with no software setup
// (R11) all interrupt sources come out of reset masked
// (R12) software must program the interrupt unit to get interrupts
// (R13) fault indicator lit at reset, changed only by a control word write
// (R14) buffer beyond half full raises an interrupt when enabled
// (R15) host write while buffer full ends with a bus error
// (R16) each node has its own number; own frames are never taken back
// (R17) incoming frames are parity checked and errors reported to the host
// (R18) link offsets are relative to the 1 Mbyte window position
// (R19) frame carries source, offset, byte lanes, data and parity
module rmn_node
  import rmn_pkg::*;
#(
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [STRB_W-1:0] pstrb,
  input wire logic [2:0] pprot,
  output logic pready,
  output logic [DATA_W-1:0] prdata,
  output logic pslverr,
  // board straps
  input wire logic [NODE_W-1:0] strap_node_id,
  input wire logic [1:0] strap_am_mode,
  input wire logic strap_a32_en,
  input wire logic [EXT_W-1:0] strap_ext_base,
  input wire logic [STD_W-1:0] strap_std_base,
  // link transmit
  output logic link_tx_valid,
  output logic [FRAME_W-1:0] link_tx_frame,
  input wire logic link_tx_ready,
  // link receive
  input wire logic link_rx_valid,
  input wire logic [FRAME_W-1:0] link_rx_frame,
  // indications
  output logic fault_indicator,
  output logic [LVL_W-1:0] irq_level
);

  localparam int CNT_W = $clog2(FIFO_DEPTH) + 1;
  localparam logic [CNT_W-1:0] HALF_CNT = CNT_W'(FIFO_DEPTH / 2);

  // ==========================================================
  // declarations
  logic [NODE_W-1:0] node_id_ff;
  logic [1:0] am_mode_ff;
  logic a32_en_ff;
  logic [EXT_W-1:0] ext_base_ff;
  logic [STD_W-1:0] std_base_ff;
  rmn_state_t st_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [DATA_W-1:0] prdata_ff;
  logic fault_ff;
  logic lerr_ff;
  logic [N_SRC-1:0] irq_mask_ff;
  logic irq_en_ff;
  logic [LVL_W-1:0] irq_lvl_ff;
  logic [N_SRC-1:0] irq_stat_ff;
  logic [LVL_W-1:0] irq_level_ff;
  logic tx_valid_ff;
  logic [FRAME_W-1:0] tx_frame_ff;
  logic acc;
  logic mem_hit;
  logic reg_hit;
  logic [REG_OFF_W-1:0] reg_off;
  logic reg_wr;
  logic csr_wr;
  logic ctrl_wr;
  logic stat_wr;
  logic send_wr;
  logic reg_err;
  logic [DATA_W-1:0] reg_rdata;
  logic rx_par_ok;
  logic rx_ok;
  logic rx_wr;
  logic rx_irq;
  logic rx_err;
  logic [NODE_W-1:0] rx_src;
  logic [OFF_W-1:0] rx_off;
  logic [STRB_W-1:0] rx_strb;
  logic [DATA_W-1:0] rx_data;
  logic host_mem;
  logic host_mem_wr;
  logic push;
  logic [FRAME_W-1:0] push_frame;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [FRAME_W-1:0] fifo_out_data;
  logic [CNT_W-1:0] fifo_count;
  logic fifo_half;
  logic ram_en;
  logic ram_we;
  logic [STRB_W-1:0] ram_strb;
  logic [MEM_AW-1:0] ram_addr;
  logic [DATA_W-1:0] ram_wdata;
  logic [DATA_W-1:0] ram_rdata;
  logic [N_SRC-1:0] irq_set;
  logic [N_SRC-1:0] irq_clr;

  // ==========================================================
  // functions

  // (R3) privilege and space check of the host window
  function automatic logic win_hit(input logic [ADDR_W-1:0] addr, input logic priv);
    logic priv_ok;
    logic space_ok;
    priv_ok = (am_mode_ff == AM_SUPER) ? priv :
              (am_mode_ff == AM_USER) ? !priv : 1'b1;
    // (R4) a32 uses the extended field, a24 needs the top byte clear
    space_ok = a32_en_ff ? (addr[EXT_LSB +: EXT_W] == ext_base_ff)
                         : (addr[EXT_LSB +: EXT_W] == EXT_A24);
    return priv_ok & space_ok & (addr[STD_LSB +: STD_W] == std_base_ff);
  endfunction : win_hit

  // (R19) pack one link frame with parity on top
  function automatic logic [FRAME_W-1:0] build_frame(
    input logic ftype,
    input logic [NODE_W-1:0] src,
    input logic [OFF_W-1:0] off,
    input logic [STRB_W-1:0] strb,
    input logic [DATA_W-1:0] data
  );
    logic [FRAME_W-1:0] f;
    f = '0;
    f[FR_TYPE_BIT] = ftype;
    f[FR_SRC_LSB +: NODE_W] = src;
    f[FR_OFF_LSB +: OFF_W] = off;
    f[FR_STRB_LSB +: STRB_W] = strb;
    f[FR_DATA_LSB +: DATA_W] = data;
    f[FR_PAR_BIT] = frame_parity(f);
    return f;
  endfunction : build_frame

  // ==========================================================
  // straps

  // (R2) jumper values follow the pins once reset is released
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      node_id_ff <= '0;
      am_mode_ff <= AM_BOTH;
      a32_en_ff <= 1'b0;
      ext_base_ff <= '0;
      std_base_ff <= '0;
    end else begin
      node_id_ff <= strap_node_id;
      am_mode_ff <= strap_am_mode;
      a32_en_ff <= strap_a32_en;
      ext_base_ff <= strap_ext_base;
      std_base_ff <= strap_std_base;
    end
  end

  // ==========================================================
  // host decode
  assign acc = psel & penable & ~pready_ff & (st_ff == ST_IDLE);
  assign reg_hit = (paddr[ADDR_W-1:REG_PAGE_LSB] == REG_PAGE);
  assign mem_hit = ~reg_hit & win_hit(paddr, pprot[PROT_PRIV_BIT]);
  assign reg_off = paddr[REG_OFF_W-1:0];
  assign reg_wr = acc & reg_hit & pwrite;
  assign csr_wr = reg_wr & (reg_off == REG_CSR);
  assign ctrl_wr = reg_wr & (reg_off == REG_IRQ_CTRL);
  assign stat_wr = reg_wr & (reg_off == REG_IRQ_STAT);
  assign send_wr = reg_wr & (reg_off == REG_IRQ_SEND);

  // ==========================================================
  // link receive

  // (R17) parity check of each arriving frame
  assign rx_par_ok = (frame_parity(link_rx_frame) == link_rx_frame[FR_PAR_BIT]);
  assign rx_err = link_rx_valid & ~rx_par_ok;
  assign rx_src = link_rx_frame[FR_SRC_LSB +: NODE_W];
  assign rx_off = link_rx_frame[FR_OFF_LSB +: OFF_W];
  assign rx_strb = link_rx_frame[FR_STRB_LSB +: STRB_W];
  assign rx_data = link_rx_frame[FR_DATA_LSB +: DATA_W];
  // (R16) frames carrying our own number have gone round and are dropped
  assign rx_ok = link_rx_valid & rx_par_ok & (rx_src != node_id_ff);
  // (R18) accept only when the 1 Mbyte position matches ours
  assign rx_wr = rx_ok & (link_rx_frame[FR_TYPE_BIT] == FR_WRITE)
               & (rx_off[OFF_W-1 -: POS_W] == std_base_ff[POS_W-1:0]);
  // (R7) interrupt frames addressed to us or to everyone
  assign rx_irq = rx_ok & (link_rx_frame[FR_TYPE_BIT] == FR_IRQ)
                & (rx_data[SEND_BCAST_BIT] | (rx_data[NODE_W-1:0] == node_id_ff));

  // ==========================================================
  // shared memory port

  // (R9) a host memory access waits while a link write owns the port
  assign host_mem = acc & mem_hit & ~rx_wr;
  // (R15) no memory write and no frame when the buffer is full
  assign host_mem_wr = host_mem & pwrite & fifo_in_ready;

  // link write first, host second
  always_comb begin
    if (rx_wr) begin
      ram_en = 1'b1;
      ram_we = 1'b1;
      ram_addr = rx_off[MEM_AW-1:0];
      ram_strb = rx_strb;
      ram_wdata = rx_data;
    end else begin
      ram_en = host_mem & (~pwrite | fifo_in_ready);
      ram_we = pwrite;
      ram_addr = paddr[WORD_LSB +: MEM_AW];
      // (R5) byte lanes follow the write strobes
      ram_strb = pstrb;
      ram_wdata = pwdata;
    end
  end

  // (R8) 256 Kbyte local memory
  rmn_sram #(
    .AW(MEM_AW),
    .DW(DATA_W)
  ) u_sram (
    .clk(pclk),
    .rst_n(presetn),
    .en(ram_en),
    .we(ram_we),
    .strb(ram_strb),
    .addr(ram_addr),
    .wdata(ram_wdata),
    .rdata(ram_rdata)
  );

  // ==========================================================
  // outgoing buffer

  // (R1) each accepted host write is copied into the buffer
  assign push = host_mem_wr | (send_wr & fifo_in_ready);
  assign push_frame = host_mem_wr
    ? build_frame(FR_WRITE, node_id_ff, paddr[WORD_LSB +: OFF_W], pstrb, pwdata)
    : build_frame(FR_IRQ, node_id_ff, '0, '0, pwdata);
  assign fifo_out_ready = ~tx_valid_ff | link_tx_ready;
  // (R14) beyond half capacity
  assign fifo_half = (fifo_count > HALF_CNT);

  // (R8) 512 byte outgoing buffer
  rmn_fifo #(
    .W(FRAME_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(push_frame),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data),
    .count(fifo_count)
  );

  // (R10) transmit stage runs from reset, held while the link stalls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_valid_ff <= 1'b0;
      tx_frame_ff <= '0;
    end else if (fifo_out_ready) begin
      tx_valid_ff <= fifo_out_valid;
      tx_frame_ff <= fifo_out_data;
    end
  end

  // ==========================================================
  // registers

  // read mux of the register page
  always_comb begin
    reg_rdata = '0;
    reg_err = 1'b0;
    case (reg_off)
      REG_CSR: begin
        reg_rdata[CSR_FAULT] = fault_ff;
        reg_rdata[CSR_HALF] = fifo_half;
        reg_rdata[CSR_FULL] = ~fifo_in_ready;
        reg_rdata[CSR_LERR] = lerr_ff;
        reg_rdata[CSR_NODE_LSB +: NODE_W] = node_id_ff;
      end
      REG_IRQ_CTRL: begin
        reg_rdata[IC_MASK_LSB +: N_SRC] = irq_mask_ff;
        reg_rdata[IC_EN] = irq_en_ff;
        reg_rdata[IC_LVL_LSB +: LVL_W] = irq_lvl_ff;
      end
      REG_IRQ_STAT: begin
        reg_rdata[N_SRC-1:0] = irq_stat_ff;
      end
      REG_IRQ_SEND: begin
        // (R15) a send refused while full
        reg_err = pwrite & ~fifo_in_ready;
      end
      default: begin
        reg_err = 1'b1;
      end
    endcase
  end

  // (R13) fault indicator lit from reset, only a control word write moves it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_ff <= FAULT_RST;
    end else if (csr_wr) begin
      fault_ff <= pwdata[CSR_FAULT];
    end
  end

  // (R17) sticky link error, a new error wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lerr_ff <= 1'b0;
    end else begin
      lerr_ff <= rx_err | (lerr_ff & ~(csr_wr & pwdata[CSR_LERR]));
    end
  end

  // (R11) interrupt control comes out of reset all masked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_ff <= '0;
      irq_en_ff <= 1'b0;
      irq_lvl_ff <= IRQ_NONE;
    end else if (ctrl_wr) begin
      irq_mask_ff <= pwdata[IC_MASK_LSB +: N_SRC];
      irq_en_ff <= pwdata[IC_EN];
      irq_lvl_ff <= pwdata[IC_LVL_LSB +: LVL_W];
    end
  end

  // sticky sources, write one to clear, set wins
  always_comb begin
    irq_set = '0;
    // (R14) half-full warning source
    irq_set[SRC_HALF] = fifo_half;
    irq_set[SRC_ATTN] = rx_irq;
    irq_set[SRC_LERR] = rx_err;
    irq_clr = stat_wr ? pwdata[N_SRC-1:0] : '0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_ff <= '0;
    end else begin
      irq_stat_ff <= irq_set | (irq_stat_ff & ~irq_clr);
    end
  end

  // (R6) pending unmasked source drives the programmed level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_level_ff <= IRQ_NONE;
    end else if (irq_en_ff && |(irq_stat_ff & irq_mask_ff)) begin
      irq_level_ff <= irq_lvl_ff;
    end else begin
      irq_level_ff <= IRQ_NONE;
    end
  end

  // ==========================================================
  // apb answer sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= ST_IDLE;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end else begin
      case (st_ff)
        ST_IDLE: begin
          pready_ff <= 1'b0;
          pslverr_ff <= 1'b0;
          if (acc && reg_hit) begin
            st_ff <= ST_DONE;
            pready_ff <= 1'b1;
            pslverr_ff <= reg_err;
            prdata_ff <= reg_rdata;
          end else if (acc && mem_hit) begin
            // (R9) stay here while the link write takes the memory
            if (!rx_wr && pwrite) begin
              st_ff <= ST_DONE;
              pready_ff <= 1'b1;
              // (R15) full buffer answers with a bus error
              pslverr_ff <= ~fifo_in_ready;
              prdata_ff <= '0;
            end else if (!rx_wr) begin
              st_ff <= ST_MEMRD;
            end
          end else if (acc) begin
            // unmapped or wrong privilege
            st_ff <= ST_DONE;
            pready_ff <= 1'b1;
            pslverr_ff <= 1'b1;
            prdata_ff <= '0;
          end
        end
        ST_MEMRD: begin
          st_ff <= ST_DONE;
          pready_ff <= 1'b1;
          pslverr_ff <= 1'b0;
          prdata_ff <= ram_rdata;
        end
        ST_DONE: begin
          st_ff <= ST_IDLE;
          pready_ff <= 1'b0;
          pslverr_ff <= 1'b0;
        end
        default: begin
          st_ff <= ST_IDLE;
          pready_ff <= 1'b0;
          pslverr_ff <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // outputs
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign prdata = prdata_ff;
  assign link_tx_valid = tx_valid_ff;
  assign link_tx_frame = tx_frame_ff;
  assign fault_indicator = fault_ff;
  assign irq_level = irq_level_ff;

endmodule : rmn_node

`default_nettype wire

// [tb/rmn_node_properties.sv]
// checker of the node's apb answers, link frames and indications
`timescale 1ns/10ps
`default_nettype none

// ====
// checker
module rmn_node_properties (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // link and indications
  input wire logic link_tx_valid,
  input wire logic [63:0] link_tx_frame,
  input wire logic link_tx_ready,
  input wire logic [7:0] strap_node_id,
  input wire logic fault_indicator,
  input wire logic [2:0] irq_level
);
  logic armed_ff;

  // remembers an enabling write to the interrupt control word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_ff <= 1'b0;
    end else if (psel && penable && pready && pwrite && paddr == 32'hFFFF0004 && pwdata[4]) begin
      armed_ff <= 1'b1;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_rdy_pulse; pready |=> !pready; endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready held too long");
  property p_err_rdy; pslverr |-> pready; endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("pslverr without pready");
  property p_answer; $rose(psel && penable) |-> ##[1:8] pready; endproperty
  a_answer: assert property (p_answer) else $error("apb answer late");
  property p_tx_hold; link_tx_valid && !link_tx_ready |=> link_tx_valid && $stable(link_tx_frame);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("frame dropped while stalled");
  property p_parity; link_tx_valid |-> !(^link_tx_frame); endproperty
  a_parity: assert property (p_parity) else $error("frame parity odd");
  property p_src; link_tx_valid |-> link_tx_frame[61:54] == strap_node_id; endproperty
  a_src: assert property (p_src) else $error("frame source wrong");
  property p_fault; $changed(fault_indicator) |-> $past(psel && penable && pwrite); endproperty
  a_fault: assert property (p_fault) else $error("fault changed without write");
  property p_irq; irq_level != 3'h0 |-> armed_ff; endproperty
  a_irq: assert property (p_irq) else $error("interrupt before enable");
endmodule : rmn_node_properties

bind rmn_node rmn_node_properties u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .pslverr, .link_tx_valid, .link_tx_frame, .link_tx_ready, .strap_node_id,
  .fault_indicator, .irq_level);

`default_nettype wire

// [tb/rmn_peer_model.sv]
// peer node model: takes sent frames, sends frames back
`timescale 1ns/10ps
`default_nettype none

// ====
// peer
module rmn_peer_model (
  // clock
  input wire logic pclk,
  // frames from the node
  input wire logic tx_valid,
  input wire logic [63:0] tx_frame,
  output logic tx_ready,
  input wire logic stall,
  // frames to the node
  output logic rx_valid,
  output logic [63:0] rx_frame
);
  logic [63:0] got[$];

  // no frame toward the node until the first send
  initial rx_valid = 1'b0;

  always @(posedge pclk) begin
    if (tx_valid && tx_ready) got.push_back(tx_frame);
    tx_ready <= !stall && $urandom_range(0, 2) != 0;
  end

  // one frame for one cycle, then scrambled idle lines
  task automatic send(input logic [63:0] f);
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_frame <= f;
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_frame <= ~f;
  endtask : send
endmodule : rmn_peer_model

`default_nettype wire

// [tb/rmn_node_bench.sv]
// self-checking bench of the reflective memory node
`timescale 1ns/10ps
`default_nettype none

// ====
// bench
module rmn_node_bench;
  import rmn_pkg::*;
  localparam logic [31:0] BASE = 32'hA5240000;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, stall = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd, a, d;
  logic [3:0] pstrb = 4'hF, s;
  logic [2:0] pprot = 3'h1, irq;
  logic [1:0] am = 2'h2;
  logic pready, pslverr, er, tx_valid, tx_ready, rx_valid, fault;
  logic [63:0] tx_frame, rx_frame, q[$];
  int n_mismatch = 0, n_compared = 0, i;

  // clock
  always #12.5 pclk = ~pclk;

  rmn_node #(.FIFO_DEPTH(16)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .pprot, .pready, .prdata, .pslverr, .strap_node_id(8'h05), .strap_am_mode(am),
    .strap_a32_en(1'b1), .strap_ext_base(8'hA5), .strap_std_base(6'h09),
    .link_tx_valid(tx_valid), .link_tx_frame(tx_frame), .link_tx_ready(tx_ready),
    .link_rx_valid(rx_valid), .link_rx_frame(rx_frame), .fault_indicator(fault),
    .irq_level(irq));
  rmn_peer_model u_peer (.pclk, .tx_valid, .tx_frame, .tx_ready, .stall, .rx_valid, .rx_frame);

  task automatic end_of_test;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [63:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // frame with even parity on top
  function automatic logic [63:0] fr(logic t, logic [7:0] sr, logic [17:0] o, logic [3:0] b,
    logic [31:0] v);
    return {^{t, sr, o, b, v}, t, sr, o, b, v};
  endfunction : fr

  function automatic logic [31:0] mrg(logic [31:0] o, nw, logic [3:0] b);
    for (int k = 0; k < 4; k++) if (b[k]) o[8*k+:8] = nw[8*k+:8];
    return o;
  endfunction : mrg

  // one apb transfer, answer taken at the pready edge
  task automatic apb(input logic w, input logic [31:0] ad, dt, input logic [3:0] b);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= dt;
    pstrb <= b;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 60 && pready !== 1'b1; n++) @(posedge pclk);
    if (pready !== 1'b1) begin
      chk("pready", 0, 1);
      end_of_test();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic drain;
    for (int n = 0; n < 900 && u_peer.got.size() < q.size(); n++) @(posedge pclk);
    chk("frames", u_peer.got.size(), q.size());
    if (u_peer.got.size() < q.size()) end_of_test();
    foreach (q[k]) if (k < u_peer.got.size()) chk("frame", u_peer.got[k], q[k]);
    q.delete();
    u_peer.got.delete();
  endtask : drain

  initial begin
    void'($urandom(87558));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("fault", fault, 1);
    apb(0, 32'hFFFF0000, 0, 4'hF);
    chk("csr", rd, 32'h501);
    apb(0, 32'hFFFF0004, 0, 4'hF);
    chk("ctrl", rd, 0);
    $display("test reset done");
    for (i = 0; i < 6; i++) begin
      a = BASE | ($urandom & 32'h3FFFC);
      d = $urandom;
      s = 4'($urandom_range(1, 15));
      apb(1, a, d, 4'hF);
      apb(1, a, ~d, s);
      apb(0, a, 0, 4'hF);
      chk("mem", rd, mrg(d, ~d, s));
      q.push_back(fr(0, 8'h05, a[19:2], 4'hF, d));
      q.push_back(fr(0, 8'h05, a[19:2], s, ~d));
    end
    apb(1, 32'hFFFF000C, 32'h100, 4'hF);
    q.push_back(fr(1, 8'h05, 0, 0, 32'h100));
    drain();
    $display("test forward done");
    u_peer.send(fr(0, 8'h07, 18'h10010, 4'hF, 32'h1234ABCD));
    u_peer.send(fr(0, 8'h05, 18'h10010, 4'hF, 32'h0));
    apb(0, BASE | 32'h40, 0, 4'hF);
    chk("rx mem", rd, 32'h1234ABCD);
    u_peer.send(fr(0, 8'h07, 18'h10020, 4'hF, 32'h0) ^ 64'h1);
    u_peer.send(fr(1, 8'h07, 0, 0, 32'h005));
    apb(0, 32'hFFFF0000, 0, 4'hF);
    chk("link err", rd[3], 1);
    apb(0, 32'hFFFF0008, 0, 4'hF);
    chk("attention", rd[1], 1);
    $display("test receive done");
    apb(1, BASE ^ 32'h01000000, 0, 4'hF);
    chk("space", er, 1);
    apb(0, 32'hFFFF0010, 0, 4'hF);
    chk("unmapped", er, 1);
    am <= 2'h1;
    apb(0, BASE, 0, 4'hF);
    chk("user only", er, 1);
    pprot <= 3'h0;
    apb(0, BASE, 0, 4'hF);
    chk("user ok", er, 0);
    pprot <= 3'h1;
    am <= 2'h0;
    apb(0, BASE, 0, 4'hF);
    chk("super only", er, 0);
    am <= 2'h2;
    apb(1, 32'hFFFF0000, 0, 4'hF);
    chk("fault off", fault, 0);
    $display("test errors done");
    apb(1, 32'hFFFF0004, 32'h311, 4'hF);
    @(posedge pclk);
    chk("masked", irq, 0);
    stall <= 1'b1;
    er = 1'b0;
    for (i = 0; i < 20 && !er; i++) apb(1, BASE | (i << 2), i, 4'hF);
    chk("full", er, 1);
    chk("depth", i > 16, 1);
    chk("irq level", irq, 3);
    for (int k = 0; k < i - 1; k++) q.push_back(fr(0, 8'h05, 18'h10000 | k, 4'hF, k));
    stall <= 1'b0;
    drain();
    $display("test full done");
    end_of_test();
  end
endmodule : rmn_node_bench

`default_nettype wire
